// ---- hw/spgs_defines.vh ----
`ifndef SPGS_DEFINES_VH
`define SPGS_DEFINES_VH
// Pin indices within the shared port nibble.
`define SPGS_PIN_SCK 2'h0
`define SPGS_PIN_MOSI 2'h1
`define SPGS_PIN_MISO 2'h2
`define SPGS_PIN_SEL 2'h3
// Reset value of the function select: all pins serial.
`define SPGS_FUNC_RST 4'h0
`define SPGS_DIR_RST 4'h0
// Synchronisers start at the idle pin levels, select high and clock low, so that
// no phantom selection or clock edge is seen right after reset.
`define SPGS_SYNC_RST 4'h8
`define SPGS_WORD_W 8
`define SPGS_HALF_DIV 8'h04
`define SPGS_BIT_LAST 3'h7
// Master state codes.
`define SPGS_ST_IDLE 2'h0
`define SPGS_ST_LOW 2'h1
`define SPGS_ST_HIGH 2'h2
`endif

// ---- hw/spgs_top.v ----
`include "spgs_defines.vh"
module spgs_top #(
  parameter WORD_W = `SPGS_WORD_W
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_n_i,
  // Configuration.
  input wire master_mode_i,
  input wire [3:0] gpio_func_i,
  input wire [3:0] gpio_dir_i,
  input wire [3:0] gpio_out_i,
  output wire [3:0] gpio_in_o,
  // Transmit stream.
  input wire [WORD_W-1:0] tx_data_i,
  input wire tx_valid_i,
  output wire tx_ready_o,
  // Receive stream.
  output wire [WORD_W-1:0] rx_data_o,
  output wire rx_valid_o,
  input wire rx_ready_i,
  output reg mode_fault_o,
  // Shared pins: index 0 clock, 1 master out, 2 master in, 3 select.
  input wire [3:0] pin_i,
  output wire [3:0] pin_o,
  output wire [3:0] pin_oe_n_o
);
  reg [3:0] sync1_ff;
  reg [3:0] sync2_ff;
  reg [3:0] func_ff;
  reg [3:0] dir_ff;
  reg [3:0] gout_ff;
  reg [1:0] state_ff;
  reg [7:0] div_ff;
  reg [2:0] bit_ff;
  reg [WORD_W-1:0] sh_ff;
  reg [WORD_W-1:0] rsh_ff;
  reg sck_ff;
  reg sck_prev_ff;
  reg mosi_ff;
  reg miso_ff;
  reg done_ff;
  reg [WORD_W-1:0] done_data_ff;
  reg [WORD_W-1:0] buf_data_ff [0:1];
  reg [1:0] buf_cnt_ff;
  reg buf_rd_ff;
  reg buf_wr_ff;
  reg [WORD_W-1:0] rx_data_ff;

  wire sp_sck = func_ff[`SPGS_PIN_SCK] ? 1'b0 : sync2_ff[`SPGS_PIN_SCK];
  wire sp_mosi = func_ff[`SPGS_PIN_MOSI] ? 1'b0 : sync2_ff[`SPGS_PIN_MOSI];
  wire sp_miso = func_ff[`SPGS_PIN_MISO] ? 1'b0 : sync2_ff[`SPGS_PIN_MISO];
  wire sel_n = func_ff[`SPGS_PIN_SEL] ? 1'b1 : sync2_ff[`SPGS_PIN_SEL];
  wire slv_sel = ~master_mode_i & ~sel_n;
  wire sck_rise = sp_sck & ~sck_prev_ff;
  wire sck_fall = ~sp_sck & sck_prev_ff;
  wire buf_full = (buf_cnt_ff == 2'h2);
  wire buf_empty = (buf_cnt_ff == 2'h0);

  // The serial logic drives a pin only when it owns that pin.
  wire [3:0] sp_oe;
  assign sp_oe[`SPGS_PIN_SCK] = master_mode_i;
  assign sp_oe[`SPGS_PIN_MOSI] = master_mode_i;
  assign sp_oe[`SPGS_PIN_MISO] = slv_sel;
  assign sp_oe[`SPGS_PIN_SEL] = 1'b0;
  wire [3:0] sp_val = {1'b0, miso_ff, mosi_ff, sck_ff};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      assign pin_o[g] = func_ff[g] ? gout_ff[g] : sp_val[g];
      assign pin_oe_n_o[g] = func_ff[g] ? ~dir_ff[g] : ~sp_oe[g];
      assign gpio_in_o[g] = func_ff[g] & sync2_ff[g];
    end
  endgenerate

  // A master offers to take a word only when the word it will receive has room,
  // counting one that is still on its way into the buffer.
  assign tx_ready_o = master_mode_i ? (state_ff == `SPGS_ST_IDLE) & ~done_ff & ~buf_full & sel_n
                                    : (bit_ff == 3'h0) & ~slv_sel;
  assign rx_valid_o = ~buf_empty;
  assign rx_data_o = buf_data_ff[buf_rd_ff];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= `SPGS_SYNC_RST;
      sync2_ff <= `SPGS_SYNC_RST;
      func_ff <= `SPGS_FUNC_RST;
      dir_ff <= `SPGS_DIR_RST;
      gout_ff <= 4'h0;
      sck_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
      func_ff <= gpio_func_i;
      dir_ff <= gpio_dir_i;
      gout_ff <= gpio_out_i;
      sck_prev_ff <= sp_sck;
    end
  end

  // Serial engine: mode 0, data changes on falling clock, captured on rising.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= `SPGS_ST_IDLE;
      div_ff <= 8'h00;
      bit_ff <= 3'h0;
      sh_ff <= {WORD_W{1'b0}};
      rsh_ff <= {WORD_W{1'b0}};
      sck_ff <= 1'b0;
      mosi_ff <= 1'b0;
      miso_ff <= 1'b0;
      done_ff <= 1'b0;
      done_data_ff <= {WORD_W{1'b0}};
      mode_fault_o <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (master_mode_i) begin
        if (!sel_n) begin
          // Another master pulled select low: abort and park the clock low; the clock and data pins stay driven.
          mode_fault_o <= 1'b1;
          state_ff <= `SPGS_ST_IDLE;
          sck_ff <= 1'b0;
        end else begin
          mode_fault_o <= 1'b0;
          case (state_ff)
            `SPGS_ST_IDLE: begin
              if (tx_valid_i && !buf_full && !done_ff) begin
                sh_ff <= tx_data_i;
                mosi_ff <= tx_data_i[WORD_W-1];
                bit_ff <= 3'h0;
                div_ff <= `SPGS_HALF_DIV;
                state_ff <= `SPGS_ST_LOW;
              end
            end
            `SPGS_ST_LOW: begin
              if (div_ff == 8'h00) begin
                sck_ff <= 1'b1;
                rsh_ff <= {rsh_ff[WORD_W-2:0], sp_miso};
                div_ff <= `SPGS_HALF_DIV;
                state_ff <= `SPGS_ST_HIGH;
              end else begin
                div_ff <= div_ff - 8'h01;
              end
            end
            `SPGS_ST_HIGH: begin
              if (div_ff == 8'h00) begin
                sck_ff <= 1'b0;
                div_ff <= `SPGS_HALF_DIV;
                if (bit_ff == `SPGS_BIT_LAST) begin
                  done_ff <= 1'b1;
                  done_data_ff <= rsh_ff;
                  state_ff <= `SPGS_ST_IDLE;
                end else begin
                  // Next bit goes out a half period before the next rising edge.
                  sh_ff <= {sh_ff[WORD_W-2:0], 1'b0};
                  mosi_ff <= sh_ff[WORD_W-2];
                  bit_ff <= bit_ff + 3'h1;
                  state_ff <= `SPGS_ST_LOW;
                end
              end else begin
                div_ff <= div_ff - 8'h01;
              end
            end
            default: state_ff <= `SPGS_ST_IDLE;
          endcase
        end
      end else begin
        mode_fault_o <= 1'b0;
        state_ff <= `SPGS_ST_IDLE;
        sck_ff <= 1'b0;
        if (!slv_sel) begin
          bit_ff <= 3'h0;
          if (tx_valid_i) begin
            sh_ff <= tx_data_i;
            miso_ff <= tx_data_i[WORD_W-1];
          end
        end else if (sck_rise) begin
          rsh_ff <= {rsh_ff[WORD_W-2:0], sp_mosi};
          bit_ff <= bit_ff + 3'h1;
          if (bit_ff == `SPGS_BIT_LAST) begin
            done_ff <= 1'b1;
            done_data_ff <= {rsh_ff[WORD_W-2:0], sp_mosi};
          end
        end else if (sck_fall) begin
          sh_ff <= {sh_ff[WORD_W-2:0], 1'b0};
          miso_ff <= sh_ff[WORD_W-2];
        end
      end
    end
  end

  // Two-entry receive buffer; a master waits for room before starting.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_cnt_ff <= 2'h0;
      buf_rd_ff <= 1'b0;
      buf_wr_ff <= 1'b0;
      buf_data_ff[0] <= {WORD_W{1'b0}};
      buf_data_ff[1] <= {WORD_W{1'b0}};
    end else begin
      if (done_ff && !buf_full) begin
        buf_data_ff[buf_wr_ff] <= done_data_ff;
        buf_wr_ff <= ~buf_wr_ff;
      end
      if (rx_ready_i && !buf_empty) begin
        buf_rd_ff <= ~buf_rd_ff;
      end
      case ({done_ff && !buf_full, rx_ready_i && !buf_empty})
        2'b10: buf_cnt_ff <= buf_cnt_ff + 2'h1;
        2'b01: buf_cnt_ff <= buf_cnt_ff - 2'h1;
        default: buf_cnt_ff <= buf_cnt_ff;
      endcase
    end
  end
endmodule // spgs_top

// ---- tb/spgs_checker.sv ----
module spgs_checker #(parameter WORD_W = 8) (
  // Clock, reset and configuration.
  input wire logic clk_i, rst_n_i, master_mode_i,
  input wire logic [3:0] gpio_func_i, gpio_dir_i, gpio_out_i, gpio_in_o,
  // Stream and shared pins.
  input wire logic [WORD_W-1:0] rx_data_o,
  input wire logic rx_valid_o, rx_ready_i, mode_fault_o,
  input wire logic [3:0] pin_i, pin_o, pin_oe_n_o
);
  logic [12:0] cfg_ff;
  logic calm;
  // Function select is registered, so pin checks wait until the setup has held a cycle.
  always_ff @(posedge clk_i) cfg_ff <= {master_mode_i, gpio_func_i, gpio_dir_i, gpio_out_i};
  assign calm = cfg_ff == {master_mode_i, gpio_func_i, gpio_dir_i, gpio_out_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence sck_low5; !pin_o[0] [*5]; endsequence
  sequence sel_low3; (calm && master_mode_i && !gpio_func_i[3] && !pin_i[3]) [*3]; endsequence
  master_drive_a: assert property (
    calm && master_mode_i && gpio_func_i[1:0] == 2'b00 |-> pin_oe_n_o[1:0] == 2'b00)
    else $error("master clock or data not driven");
  slave_listen_a: assert property (
    calm && !master_mode_i && gpio_func_i[1:0] == 2'b00 |-> pin_oe_n_o[1:0] == 2'b11)
    else $error("slave drives clock or data");
  master_in_a: assert property (
    calm && master_mode_i && !gpio_func_i[2] |-> pin_oe_n_o[2]) else $error("master drives miso");
  miso_release_a: assert property (
    (calm && !master_mode_i && !gpio_func_i[2] && pin_i[3]) [*4] |-> pin_oe_n_o[2])
    else $error("unselected slave drives miso");
  data_lead_a: assert property (
    calm && master_mode_i && gpio_func_i[1:0] == 2'b00 && $changed(pin_o[1]) |-> sck_low5)
    else $error("data changed too close to clock rise");
  fault_seen_a: assert property (sel_low3 |=> mode_fault_o)
    else $error("select low not flagged");
  gpio_drive_a: assert property (
    calm |-> ((pin_oe_n_o ^ ~gpio_dir_i) & gpio_func_i) == 4'h0
    && ((pin_o ^ gpio_out_i) & gpio_func_i & gpio_dir_i) == 4'h0)
    else $error("port bit drive wrong");
  gpio_hide_a: assert property (calm |-> (gpio_in_o & ~gpio_func_i) == 4'h0)
    else $error("serial pin seen by port");
  rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("received word dropped");
endmodule // spgs_checker
bind spgs_top spgs_checker #(.WORD_W(WORD_W)) spgs_checker_i (.*);

// ---- tb/spgs_peer.sv ----
module spgs_peer (
  input wire logic sck, sel_n, mosi,
  input wire logic [7:0] load,
  output logic miso,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] n = 3'h0;
  logic m = 1'b0;
  always @(posedge sck or posedge sel_n) if (sel_n) n <= 3'h0; else begin
    n <= n + 3'h1;
    got <= {got[6:0], mosi};
  end
  always @(negedge sck or posedge sel_n) if (sel_n) m <= load[7]; else m <= load[3'h7 - n];
  // A released line shows the inverse of bit 7 of the loaded word so a stale read is caught.
  assign miso = sel_n ? ~m : m;
endmodule // spgs_peer

// ---- tb/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
  logic clk_i = 0, rst_n_i = 0, mm = 0, txv = 0, rxr = 1, sel_n = 0, txr, rxv, mf, miso;
  logic [3:0] fn = 0, dr = 0, go = 0, ex = 4'h8, gi, po, oe, pi;
  logic [7:0] txd = 0, ld = 0, rxd, got, sw, exp_w;
  logic [7:0] q[$];
  logic [15:0] r = 16'hdd56;
  int err_count = 0, total_checks = 0, cyc = 0;
  always #10 clk_i = ~clk_i;
  assign pi = (~oe & po) | (oe & {ex[3], fn[2] ? ex[2] : miso, ex[1:0]});
  spgs_top spgs_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .master_mode_i(mm), .gpio_func_i(fn),
    .gpio_dir_i(dr), .gpio_out_i(go), .gpio_in_o(gi), .tx_data_i(txd), .tx_valid_i(txv),
    .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr), .mode_fault_o(mf),
    .pin_i(pi), .pin_o(po), .pin_oe_n_o(oe));
  spgs_peer spgs_peer_i (.sck(pi[0]), .sel_n(sel_n), .mosi(pi[1]), .load(ld), .miso(miso),
    .got(got));
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Each word is framed by the peer's own select so it reloads its shifter.
  task send;
    r = nx(r);
    ld = r[7:0];
    txd = r[15:8];
    q.push_back(ld);
    sel_n = 1;
    @(negedge clk_i);
    sel_n = 0;
    txv = 1;
    while (!txr) @(negedge clk_i);
    @(negedge clk_i);
    txv = 0;
    repeat (90) @(negedge clk_i);
    `CHK(got, txd)
  endtask
  // The bench plays the far master: data moves with the falling clock, half a period ahead.
  task slave_xfer;
    r = nx(r);
    txd = r[7:0];
    ld = r[15:8];
    txv = 1;
    @(negedge clk_i);
    txv = 0;
    q.push_back(ld);
    ex[3] = 0;
    repeat (4) @(negedge clk_i);
    `CHK(oe, 4'hb)
    for (int i = 7; i >= 0; i--) begin
      ex[1] = ld[i];
      repeat (4) @(negedge clk_i);
      sw[i] = pi[2];
      ex[0] = 1;
      repeat (4) @(negedge clk_i);
      ex[0] = 0;
    end
    ex[3] = 1;
    repeat (6) @(negedge clk_i);
    `CHK(sw, txd)
    `CHK(oe, 4'hf)
  endtask
  always @(posedge clk_i) if (rxv && rxr) begin
    exp_w = q.pop_front();
    `CHK(rxd, exp_w)
  end
  always @(posedge clk_i) if (++cyc > 5000) begin err_count++; wrap_up(); end
  initial begin
    repeat (8) @(negedge clk_i);
    rst_n_i = 1;
    @(negedge clk_i);
    `CHK(oe, 4'hf)
    mm = 1;
    repeat (2) @(negedge clk_i);
    `CHK(oe, 4'hc)
    repeat (3) send();
    $display("test transfer done");
    rxr = 0;
    repeat (2) send();
    `CHK(txr, 1'b0)
    @(negedge clk_i);
    rxr = 1;
    repeat (4) @(negedge clk_i);
    $display("test stall done");
    ex[3] = 0;
    repeat (5) @(negedge clk_i);
    `CHK(mf, 1'b1)
    ex[3] = 1;
    repeat (5) @(negedge clk_i);
    `CHK(mf, 1'b0)
    $display("test fault done");
    mm = 0;
    repeat (3) @(negedge clk_i);
    repeat (2) slave_xfer();
    $display("test slave done");
    mm = 1;
    repeat (4) begin
      r = nx(r);
      {ex, go, dr} = r[11:0];
      fn = 4'hf;
      repeat (5) @(negedge clk_i);
      `CHK(oe, ~dr)
      `CHK(po & dr, go & dr)
      `CHK(gi, pi)
      `CHK(mf, 1'b0)
    end
    $display("test port done");
    wrap_up();
  end
endmodule // tb
